//--- core/adc_mode_defs.vh
`ifndef ADC_MODE_DEFS_VH
`define ADC_MODE_DEFS_VH
// ==========================================================
// clocking
`define SYS_CLK_HZ 50000000
`define INT_OSC_HZ 64000
// half period of the internal oscillator in system cycles
`define OSC_HALF_CYC (`SYS_CLK_HZ / (2 * `INT_OSC_HZ))
// ==========================================================
// operating_configuration fields
`define MODE_SEL_HI 15
`define MODE_SEL_LO 13
`define CLK_SEL_HI 7
`define CLK_SEL_LO 6
`define RSVD_BIT 5
`define CHOP_DIS_BIT 4
`define RATE_HI 3
`define RATE_LO 0
`define CFG_RESET 16'h0001
// ==========================================================
// field codes
`define OPMODE_CONT 3'h0
`define CLKSRC_INT 2'h0
`define CLKSRC_INT_OUT 2'h1
`define CLKSRC_EXT 2'h2
`define CLKSRC_EXT_DIV2 2'h3
// ==========================================================
// serial command byte
`define CMD_WEN_BIT 7
`define CMD_RD_BIT 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 3
`define CMD_CREAD_BIT 2
`define REG_STATUS 3'h0
`define REG_CFG 3'h1
`define REG_DATA 3'h3
`define CMD_CREAD_EXIT 8'h58
// ==========================================================
// converter output period in converter clocks per rate code step
`define OUT_UNIT 16'h0040
`endif

//--- core/conv_seq.v
`timescale 1ns/100ps
`default_nettype none
`include "adc_mode_defs.vh"

module conv_seq (
   input wire clk, // system clock
   input wire nrst, // async reset, active low
   input wire conv_en, // one pulse per converter clock
   input wire run, // continuous conversion selected
   input wire restart, // configuration rewritten
   input wire chop_dis, // chopping off
   input wire [3:0] rate, // update rate select
   output reg done_q // one-cycle pulse per result
);

   // ==========================================================
   // output period length
   // code zero is taken as sixteen units so no rate has length zero
   function [15:0] out_period;
      input [3:0] r;
      begin
         if (r == 4'h0)
            out_period = `OUT_UNIT << 4;
         else
            out_period = {12'h000, r} * `OUT_UNIT;
      end
   endfunction

   reg [15:0] cnt_q; // converter clocks into this output period
   reg first_q; // first result after start still pending
   wire [15:0] period = out_period(rate);
   // first result settles over two periods with chop, one without
   wire [15:0] target = (first_q && !chop_dis) ? (period << 1) : period;

   // ==========================================================
   // period counter
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 16'h0000;
         first_q <= 1'b1;
         done_q <= 1'b0;
      end else if (!run || restart) begin
         // leaving or re-entering the mode restarts settling
         cnt_q <= 16'h0000;
         first_q <= 1'b1;
         done_q <= 1'b0;
      end else if (conv_en) begin
         if (cnt_q == target - 16'h0001) begin
            cnt_q <= 16'h0000;
            first_q <= 1'b0; // later results come once per period
            done_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
            done_q <= 1'b0;
         end
      end else begin
         done_q <= 1'b0;
      end
   end

endmodule // conv_seq
`default_nettype wire

//--- core/adc_mode_ctrl.v
// Summary of operation
// - clock select bits 7:6, 00 internal, no pin
// - code 01 internal clock, also driven out
// - code 10 external pin clock used directly
// - code 11 external pin clock halved
// - chop disable bit 4 resets to zero
// - bits 3:0 choose output data rate
// - mode select in bits 15:13
// - mode 000 continuous, default after reset
// - continuous conversions store result, ready low
// - continuous read shifts results without command
// - read command returns latest result
// - first result two periods chopped, else one
// - later results once per output period
`timescale 1ns/100ps
`default_nettype none
`include "adc_mode_defs.vh"

module adc_mode_ctrl (
   input wire clk, // system clock, 50 MHz
   input wire nrst, // async reset, active low
   input wire sclk, // serial clock pin, idles high
   input wire din, // serial data in pin
   input wire cs_n, // chip select pin, active low
   output reg dout_q, // serial data out
   output reg dout_oe_q, // data out driven while selected
   output reg rdy_n_q, // result ready, active low
   input wire clk_pin_in, // clock pin, input side
   output reg clk_pin_out_q, // clock pin, output side
   output reg clk_pin_oe_q, // clock pin drive enable
   input wire [23:0] conv_sample, // filter output word
   output reg conv_clk_en_q, // converter clock pulse to modulator
   output reg [15:0] cfg_q // operating_configuration register
);

   // ==========================================================
   // pin synchronisers: three stages, accept once stages 2 and 3 agree
   localparam NPIN = 4; // sclk, din, cs_n, clk pin
   reg [NPIN-1:0] sync1_q; // first stage, read only by sync2
   reg [NPIN-1:0] sync2_q; // second stage
   reg [NPIN-1:0] sync3_q; // third stage
   reg [NPIN-1:0] filt_q; // accepted level
   reg [NPIN-1:0] filt_p_q; // accepted level one cycle ago

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 4'hF;
         sync2_q <= 4'hF;
         sync3_q <= 4'hF;
         filt_q <= 4'hF;
         filt_p_q <= 4'hF;
      end else begin
         sync1_q <= {clk_pin_in, cs_n, din, sclk};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // a disagreement holds the old level, filtering single-cycle glitches
         filt_q <= (sync2_q & sync3_q) | ((sync2_q ^ sync3_q) & filt_q);
         filt_p_q <= filt_q;
      end
   end

   wire sclk_rise = filt_q[0] & ~filt_p_q[0]; // host samples dout, we sample din
   wire sclk_fall = ~filt_q[0] & filt_p_q[0]; // we advance dout
   wire din_f = filt_q[1]; // filtered data in
   wire cs_off = filt_q[2]; // chip deselected
   wire ext_rise = filt_q[3] & ~filt_p_q[3]; // external clock edge

   // ==========================================================
   // converter clock source
   wire [1:0] clk_sel = cfg_q[`CLK_SEL_HI:`CLK_SEL_LO];
   reg [9:0] osc_cnt_q; // internal oscillator divider
   reg osc_q; // internal 64 kHz square wave
   reg ext_half_q; // divide-by-two phase for external clock
   reg conv_en_d; // converter clock pulse, next value
   localparam [31:0] OSC_HALF_W = `OSC_HALF_CYC; // half period, rounded down
   localparam [9:0] OSC_HALF = OSC_HALF_W[9:0]; // count fits ten bits, cut on purpose

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_cnt_q <= 10'h000;
         osc_q <= 1'b0;
         ext_half_q <= 1'b0;
      end else begin
         if (osc_cnt_q == OSC_HALF - 10'h001) begin
            osc_cnt_q <= 10'h000;
            osc_q <= ~osc_q;
         end else begin
            osc_cnt_q <= osc_cnt_q + 10'h001;
         end
         if (ext_rise)
            ext_half_q <= ~ext_half_q;
      end
   end

   // pick one pulse per converter clock period
   always @* begin
      case (clk_sel)
         `CLKSRC_INT, `CLKSRC_INT_OUT: begin
            conv_en_d = (osc_cnt_q == OSC_HALF - 10'h001) & ~osc_q;
         end
         `CLKSRC_EXT: begin
            conv_en_d = ext_rise;
         end
         default: begin
            conv_en_d = ext_rise & ext_half_q; // every second edge
         end
      endcase
   end

   // clock pin drive and registered converter pulse
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_clk_en_q <= 1'b0;
         clk_pin_out_q <= 1'b0;
         clk_pin_oe_q <= 1'b0;
      end else begin
         conv_clk_en_q <= conv_en_d;
         clk_pin_out_q <= osc_q;
         // only code 01 puts the oscillator on the pin
         clk_pin_oe_q <= (clk_sel == `CLKSRC_INT_OUT);
      end
   end

   // ==========================================================
   // conversion sequencing
   reg cfg_wr_q; // pulse after a configuration write
   wire conv_done; // one pulse per finished result
   wire run = (cfg_q[`MODE_SEL_HI:`MODE_SEL_LO] == `OPMODE_CONT);

   conv_seq u_seq (
      .clk(clk),
      .nrst(nrst),
      .conv_en(conv_clk_en_q),
      .run(run),
      .restart(cfg_wr_q),
      .chop_dis(cfg_q[`CHOP_DIS_BIT]),
      .rate(cfg_q[`RATE_HI:`RATE_LO]),
      .done_q(conv_done)
   );

   reg [23:0] data_q; // latest conversion result
   reg rd_done_q; // pulse when a data read finished

   // result store and ready flag; a new result wins over a read clear
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_q <= 24'h000000;
         rdy_n_q <= 1'b1;
      end else if (conv_done) begin
         data_q <= conv_sample;
         rdy_n_q <= 1'b0;
      end else if (rd_done_q || !run) begin
         rdy_n_q <= 1'b1;
      end
   end

   // ==========================================================
   // serial port
   localparam [2:0] S_CMD = 3'b001; // collect command byte
   localparam [2:0] S_WR = 3'b010; // collect register write
   localparam [2:0] S_RD = 3'b100; // shift register read
   reg [2:0] state_q; // serial state
   reg [4:0] bit_cnt_q; // bits done in this phase
   reg [4:0] len_q; // bits in this phase
   reg [7:0] cmd_sr_q; // incoming bits
   reg [15:0] wr_sr_q; // write data being collected
   reg [23:0] shift_q; // outgoing bits, msb first
   reg [2:0] addr_q; // addressed register
   reg rd_data_q; // current read is of the data register
   reg cread_q; // continuous read active
   wire [7:0] cmd_b = {cmd_sr_q[6:0], din_f}; // byte completing now

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_CMD;
         bit_cnt_q <= 5'h00;
         len_q <= 5'h08;
         cmd_sr_q <= 8'h00;
         wr_sr_q <= 16'h0000;
         shift_q <= 24'h000000;
         addr_q <= 3'h0;
         rd_data_q <= 1'b0;
         cread_q <= 1'b0;
         cfg_q <= `CFG_RESET; // mode 000, chop on, internal clock
         cfg_wr_q <= 1'b0;
         rd_done_q <= 1'b0;
         dout_q <= 1'b1;
         dout_oe_q <= 1'b0;
      end else begin
         cfg_wr_q <= 1'b0;
         rd_done_q <= 1'b0;
         dout_oe_q <= ~cs_off;
         if (cs_off) begin
            // deselect aborts a frame; continuous read stays armed
            state_q <= S_CMD;
            bit_cnt_q <= 5'h00;
         end else begin
            case (state_q)
               S_CMD: begin
                  // the cycle after a stream ends still shows ready; skipping it keeps
                  // one result from going out twice while the host stays selected
                  if (cread_q && !rdy_n_q && !rd_done_q && bit_cnt_q == 5'h00 &&
                      !sclk_rise) begin
                     // new result goes out with no command
                     shift_q <= data_q;
                     len_q <= 5'h18;
                     rd_data_q <= 1'b1;
                     state_q <= S_RD;
                  end else if (sclk_rise) begin
                     cmd_sr_q <= cmd_b;
                     if (bit_cnt_q == 5'h07) begin
                        bit_cnt_q <= 5'h00;
                        addr_q <= cmd_b[`CMD_ADDR_HI:`CMD_ADDR_LO];
                        if (cmd_b[`CMD_WEN_BIT]) begin
                           state_q <= S_CMD; // not a command, ignored
                        end else if (cmd_b[`CMD_RD_BIT]) begin
                           state_q <= S_RD;
                           rd_data_q <= 1'b0;
                           case (cmd_b[`CMD_ADDR_HI:`CMD_ADDR_LO])
                              `REG_DATA: begin
                                 shift_q <= data_q;
                                 len_q <= 5'h18;
                                 rd_data_q <= 1'b1;
                                 cread_q <= cmd_b[`CMD_CREAD_BIT];
                              end
                              `REG_CFG: begin
                                 shift_q <= {cfg_q, 8'h00};
                                 len_q <= 5'h10;
                              end
                              `REG_STATUS: begin
                                 shift_q <= {rdy_n_q, 23'h000000};
                                 len_q <= 5'h08;
                              end
                              default: begin
                                 shift_q <= 24'h000000; // unmapped reads zero
                                 len_q <= 5'h08;
                              end
                           endcase
                        end else begin
                           state_q <= S_WR;
                           len_q <= (cmd_b[`CMD_ADDR_HI:`CMD_ADDR_LO] == `REG_CFG) ?
                                    5'h10 : 5'h08;
                        end
                     end else begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                     end
                  end
               end
               S_WR: begin
                  if (sclk_rise) begin
                     wr_sr_q <= {wr_sr_q[14:0], din_f};
                     if (bit_cnt_q == len_q - 5'h01) begin
                        bit_cnt_q <= 5'h00;
                        state_q <= S_CMD;
                        if (addr_q == `REG_CFG) begin
                           // all fields stored as written; bit 5 is the host's care
                           cfg_q <= {wr_sr_q[14:0], din_f};
                           cfg_wr_q <= 1'b1;
                        end
                     end else begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                     end
                  end
               end
               S_RD: begin
                  if (sclk_fall) begin
                     dout_q <= shift_q[23];
                     shift_q <= {shift_q[22:0], 1'b0};
                  end
                  if (sclk_rise) begin
                     // din is watched for the exit command while reading
                     cmd_sr_q <= cmd_b;
                     if (bit_cnt_q == 5'h07 && cread_q && cmd_b == `CMD_CREAD_EXIT)
                        cread_q <= 1'b0;
                     if (bit_cnt_q == len_q - 5'h01) begin
                        bit_cnt_q <= 5'h00;
                        state_q <= S_CMD;
                        rd_done_q <= rd_data_q;
                     end else begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                     end
                  end
               end
               default: begin
                  state_q <= S_CMD;
                  bit_cnt_q <= 5'h00;
               end
            endcase
         end
      end
   end

endmodule // adc_mode_ctrl
`default_nettype wire

//--- tb/adc_mode_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module adc_mode_ctrl_assertions (
   input wire logic clk, // system clock
   input wire logic nrst, // reset, active low
   input wire logic cs_n, // select, active low
   input wire logic dout_oe_q, // data out enable
   input wire logic rdy_n_q, // ready, active low
   input wire logic clk_pin_in, // clock pin level
   input wire logic clk_pin_oe_q, // clock pin drive
   input wire logic conv_clk_en_q, // converter clock
   input wire logic [15:0] cfg_q // configuration
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [15:0] cfg_p_q; // last configuration
   logic [9:0] gap_q; // cycles since pulse
   logic [10:0] np_q; // pulses since result
   logic [1:0] rc_q; // pin rises since pulse
   logic int_q, d2_q, seen_q, pin_q; // steady-run flags; pin_q is the last pin level
   wire chg = cfg_q != cfg_p_q; // rewrite restarts the flags and np_q, not gap_q or rc_q
   wire isel = !cfg_q[7]; // internal source
   wire dsel = cfg_q[7:6] == 2'h3; // halved source
   wire [10:0] per = (cfg_q[3:0] == 4'h0) ? 11'h400 : {1'b0, cfg_q[3:0], 6'h00};
   // flags skip the first gap after a rewrite, whose phase is free
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_p_q <= 16'h0001;
         pin_q <= 1'b0;
         gap_q <= 10'h000;
         rc_q <= 2'h0;
         np_q <= 11'h000;
         int_q <= 1'b0;
         d2_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         cfg_p_q <= cfg_q;
         pin_q <= clk_pin_in;
         gap_q <= conv_clk_en_q ? 10'h000 : gap_q + 10'h001;
         if (conv_clk_en_q) rc_q <= 2'h0;
         else if (clk_pin_in && !pin_q && rc_q != 2'h3) rc_q <= rc_q + 2'h1;
         int_q <= (conv_clk_en_q || int_q) && isel && !chg;
         d2_q <= (conv_clk_en_q || d2_q) && dsel && !chg;
         seen_q <= !chg && (seen_q || $fell(rdy_n_q));
         np_q <= (chg || $fell(rdy_n_q)) ? 11'h000 : np_q + {10'h000, conv_clk_en_q};
      end
   end
   AST_RST_CFG: assert property (!$past(nrst) |-> cfg_q == 16'h0001)
      else $error("configuration not at reset value");
   AST_INT_GAP: assert property (conv_clk_en_q && int_q && isel |-> gap_q == 10'h30B)
      else $error("internal clock period wrong");
   AST_PIN_OFF: assert property (cfg_q[7:6] != 2'h1 [*2] |-> !clk_pin_oe_q)
      else $error("clock pin driven");
   AST_PIN_ON: assert property (cfg_q[7:6] == 2'h1 [*2] |-> clk_pin_oe_q)
      else $error("clock pin not driven");
   AST_EXT_PULSE: assert property ($rose(clk_pin_in) && cfg_q[7:6] == 2'h2
      && $stable(cfg_q) |-> ##[1:9] (conv_clk_en_q || cfg_q[7:6] != 2'h2))
      else $error("external rise gave no converter clock");
   AST_EXT_HALF: assert property (conv_clk_en_q && d2_q && dsel |-> rc_q == 2'h2)
      else $error("external clock not halved");
   AST_IDLE_RDY: assert property (cfg_q[15:13] != 3'h0 [*3] |-> rdy_n_q)
      else $error("ready outside continuous mode");
   AST_RES_PERIOD: assert property ($fell(rdy_n_q) && seen_q |-> np_q == per)
      else $error("result spacing wrong");
   AST_OE_CS: assert property (!cs_n [*8] |-> dout_oe_q)
      else $error("data out not driven");
   AST_OE_IDLE: assert property (cs_n [*8] |-> !dout_oe_q)
      else $error("data out driven unselected");
   cover property ($fell(rdy_n_q) && seen_q);
   cover property (conv_clk_en_q && d2_q);
   cover property (conv_clk_en_q && int_q);
endmodule // adc_mode_ctrl_assertions
bind adc_mode_ctrl adc_mode_ctrl_assertions chk_u (.clk(clk), .nrst(nrst), .cs_n(cs_n),
   .dout_oe_q(dout_oe_q), .rdy_n_q(rdy_n_q), .clk_pin_in(clk_pin_in),
   .clk_pin_oe_q(clk_pin_oe_q), .conv_clk_en_q(conv_clk_en_q), .cfg_q(cfg_q));
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// serial host
module host_model (
   input wire logic clk, // system clock
   input wire logic dout, // device data out
   output logic sclk, // serial clock, idles high
   output logic din, // data to device
   output logic cs_n // select, active low
);
   initial begin
      sclk = 1'b1;
      din = 1'b1;
      cs_n = 1'b1;
   end
   // msb first, 8 clk per half bit so the pin filters keep up
   task automatic xfer(input int n, input logic [39:0] w, output logic [39:0] r);
      r = '0;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (8) @(negedge clk);
         sclk = 1'b0;
         din = w[i];
         repeat (8) @(negedge clk);
         r = {r[38:0], dout};
         sclk = 1'b1;
      end
      repeat (8) @(negedge clk);
      cs_n = 1'b1;
      din = ~din; // released line shows no stale bit
      repeat (8) @(negedge clk);
   endtask
   // configuration write as a careful host does it
   task automatic wr_cfg(input logic [15:0] v);
      logic [39:0] r;
      logic [15:0] c;
      c = v & 16'hFFDF;
      if (c[4]) c[9] = 1'b1;
      xfer(24, {16'h0000, 8'h08, c}, r);
   endtask
endmodule // host_model
`default_nettype wire

//--- tb/adc_mode_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench
module adc_mode_ctrl_test;
   logic clk, nrst, ext_q, sclk, din, cs_n, rdy_p, out_p;
   logic [23:0] conv_sample;
   logic [15:0] cfg_p;
   logic [39:0] r;
   logic [23:0] exp_q[$]; // offered samples
   int errors, checked, np, last_np, po;
   wire dout_q, dout_oe_q, rdy_n_q, clk_pin_out_q, clk_pin_oe_q, conv_clk_en_q;
   wire [15:0] cfg_q;
   wire clk_pin = clk_pin_oe_q ? clk_pin_out_q : ext_q; // shared pin level
   adc_mode_ctrl dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .din(din), .cs_n(cs_n),
      .dout_q(dout_q), .dout_oe_q(dout_oe_q), .rdy_n_q(rdy_n_q), .clk_pin_in(clk_pin),
      .clk_pin_out_q(clk_pin_out_q), .clk_pin_oe_q(clk_pin_oe_q),
      .conv_sample(conv_sample), .conv_clk_en_q(conv_clk_en_q), .cfg_q(cfg_q));
   wire dout_pin = dout_oe_q ? dout_q : ~dout_q; // undriven line shows no stale bit
   host_model host_u (.clk(clk), .dout(dout_pin), .sclk(sclk), .din(din), .cs_n(cs_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // external clock, 10 cycles a period
   initial begin
      ext_q = 1'b0;
      forever begin
         repeat (5) @(negedge clk);
         ext_q = ~ext_q;
      end
   end
   // converter pulses since rewrite or result
   always @(posedge clk) begin
      cfg_p <= cfg_q;
      rdy_p <= rdy_n_q;
      out_p <= clk_pin_out_q;
      po <= po + int'(clk_pin_out_q && !out_p);
      if (rdy_p && !rdy_n_q) last_np <= np;
      if (!nrst || cfg_q != cfg_p || (rdy_p && !rdy_n_q)) np <= 0;
      else np <= np + int'(conv_clk_en_q);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // rewrite, then clear a result that landed meanwhile
   task automatic setup(input logic [15:0] v);
      host_u.wr_cfg(v);
      if (!rdy_n_q) host_u.xfer(32, 40'h58000000, r);
   endtask
   task automatic window(input logic oe);
      int n0, p0;
      n0 = np;
      p0 = po;
      repeat (2340) @(negedge clk);
      chk(np - n0, 3);
      chk(clk_pin_oe_q, oe);
      if (oe) chk(po - p0, 3);
   endtask
   // wait for ready, check spacing, read by command or stream
   task automatic result(input int exp_np, input bit stream);
      int k;
      logic [39:0] rd;
      k = 0;
      while (rdy_n_q !== 1'b0 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      if (k == 5000) begin
         errors++;
         tally_and_finish();
      end
      @(negedge clk);
      chk(last_np, exp_np);
      if (stream) host_u.xfer(24, 40'h0, rd);
      else host_u.xfer(32, 40'h58000000, rd);
      chk(rd[23:0], exp_q[$]);
      conv_sample = 24'($urandom);
      exp_q.push_back(conv_sample);
   endtask
   initial begin
      errors = 0;
      checked = 0;
      np = 0;
      po = 0;
      nrst = 1'b0;
      void'($urandom(32'h2028));
      conv_sample = 24'($urandom);
      exp_q.push_back(conv_sample);
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
      chk(cfg_q, 16'h0001);
      host_u.xfer(24, 40'h480000, r);
      chk(r[15:0], 16'h0001);
      host_u.xfer(16, 40'h5000, r);
      chk(r[7:0], 8'h00);
      host_u.xfer(16, 40'h4000, r);
      chk(r[7:0], 8'h80);
      window(1'b0);
      setup(16'h0041);
      window(1'b1);
      setup(16'h0081);
      result(128, 1'b0);
      result(64, 1'b0);
      setup(16'h00B2);
      chk(cfg_q, 16'h0292);
      result(128, 1'b0);
      result(128, 1'b0);
      setup(16'h00D1);
      result(64, 1'b0);
      setup(16'h20D1);
      repeat (1500) @(negedge clk);
      chk(rdy_n_q, 1'b1);
      host_u.xfer(24, 40'h480000, r);
      chk(r[15:0], 16'h22D1);
      setup(16'h00D1);
      host_u.xfer(8, 40'h5C, r);
      result(64, 1'b1);
      result(64, 1'b1);
      tally_and_finish();
   end
endmodule // adc_mode_ctrl_test
`default_nettype wire
